// >>> logic/cwd_pkg.sv
/*
 configuration word decoder package: register offsets, field positions,
 encodings and reset values.
 assumes: included before any design file that names cwd_pkg.
*/
package cwd_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CFG_ONE   = 8'h00;
    localparam logic [7:0] OFF_CFG_TWO   = 8'h04;
    localparam logic [7:0] OFF_CFG_FOUR  = 8'h08;
    localparam logic [7:0] OFF_STATUS    = 8'h0c;
    localparam logic [7:0] OFF_PIN_LOCK  = 8'h10;
    localparam logic [7:0] OFF_PROG_CTRL = 8'h14;
    localparam logic [7:0] OFF_DECODED   = 8'h18;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int W1_WDT_MODE_LO = 6;
    localparam int W1_WDT_PRESC   = 4;
    localparam int W1_EMU_LO      = 8;
    localparam int W1_WRITE_PROT  = 12;
    localparam int W1_CODE_PROT   = 13;
    localparam int W1_DEBUG_EN    = 14;
    localparam int W2_OSC_LO      = 8;
    localparam int W2_TWO_SPEED   = 15;
    localparam int W3_PAGE_LO     = 0;
    localparam int W3_END_SEL     = 7;
    localparam int W3_CFG_PAGE    = 8;
    localparam int W4_I2C_LOC     = 14;
    localparam int W4_ONE_WAY     = 15;
    localparam int PL_LOCK        = 0;
    localparam int PL_UNLOCK_BIT  = 1;

    // ----------------------------------------------------------------
    // encodings and constants
    // ----------------------------------------------------------------
    localparam logic [1:0] WDT_HW_ON   = 2'h3;
    localparam logic [1:0] WDT_SOFT    = 2'h2;
    localparam logic [1:0] WDT_ACTIVE  = 2'h1;
    localparam logic [1:0] WDT_OFF     = 2'h0;
    localparam logic [1:0] EMU_RSVD    = 2'h0;
    localparam logic [7:0] PRESC_128   = 8'h80;
    localparam logic [7:0] PRESC_32    = 8'h20;
    localparam logic [6:0] CFG_PAGE_ID = 7'h7f;
    localparam logic [15:0] UNLOCK_KEY_A = 16'h0046;
    localparam logic [15:0] UNLOCK_KEY_B = 16'h0057;
    localparam logic [23:0] WORD_ERASED  = 24'hffffff;
    localparam logic [1:0] NV_ADDR_ONE  = 2'h0;
    localparam logic [1:0] NV_ADDR_TWO  = 2'h1;
    localparam logic [1:0] NV_ADDR_THREE = 2'h2;
    localparam logic [1:0] NV_ADDR_FOUR = 2'h3;

    typedef enum logic [2:0] {
        OSC_FRC      = 3'b000,
        OSC_FRC_PLL  = 3'b001,
        OSC_PRI      = 3'b010,
        OSC_PRI_PLL  = 3'b011,
        OSC_SEC      = 3'b100,
        OSC_LOW_POWER_RC_OSC     = 3'b101,
        OSC_RSVD     = 3'b110,
        OSC_FRC_DIV  = 3'b111
    } cwd_osc_t;

    typedef enum logic [2:0] {
        LD_IDLE  = 3'b000,
        LD_REQ   = 3'b001,
        LD_WAIT  = 3'b010,
        LD_NEXT  = 3'b011,
        LD_DONE  = 3'b100
    } cwd_load_t;
endpackage

// >>> logic/cwd_nv_if.sv
/*
 interface between the decoder top and its nonvolatile word loader.
 assumes: both ends on hclk.
*/
`timescale 1ns/1ps
interface cwd_nv_if;
    logic        start;
    logic        done;
    logic [23:0] word_one;
    logic [23:0] word_two;
    logic [23:0] word_three;
    logic [23:0] word_four;
    modport loader (input start, output done, word_one, word_two, word_three, word_four);
    modport user   (output start, input done, word_one, word_two, word_three, word_four);
endinterface

// >>> logic/cwd_word_loader.sv
/*
 fetches the four configuration words from nonvolatile storage one by one.
 assumes: storage answers each request with nv_valid some cycles later.
*/
`timescale 1ns/1ps
module cwd_word_loader (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    cwd_nv_if.loader         nv,
    output logic             nv_req,
    output logic [1:0]       nv_addr,
    input  wire logic [23:0] nv_rdata,
    input  wire logic        nv_valid
);
    cwd_pkg::cwd_load_t state_reg;
    logic [23:0] words_reg [4];

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= cwd_pkg::LD_IDLE;
            nv_addr   <= cwd_pkg::NV_ADDR_ONE;
        end else begin
            unique case (state_reg)
                cwd_pkg::LD_IDLE: begin
                    if (nv.start) begin
                        nv_addr   <= cwd_pkg::NV_ADDR_ONE;
                        state_reg <= cwd_pkg::LD_REQ;
                    end
                end
                cwd_pkg::LD_REQ: state_reg <= cwd_pkg::LD_WAIT;
                cwd_pkg::LD_WAIT: begin
                    if (nv_valid) begin
                        state_reg <= cwd_pkg::LD_NEXT;
                    end
                end
                cwd_pkg::LD_NEXT: begin
                    if (nv_addr == cwd_pkg::NV_ADDR_FOUR) begin
                        state_reg <= cwd_pkg::LD_DONE;
                    end else begin
                        nv_addr   <= nv_addr + 2'h1;
                        state_reg <= cwd_pkg::LD_REQ;
                    end
                end
                cwd_pkg::LD_DONE: state_reg <= cwd_pkg::LD_DONE;
                default: state_reg <= cwd_pkg::LD_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // word capture, erased value until read
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                words_reg[i] <= cwd_pkg::WORD_ERASED;
            end
        end else if (state_reg == cwd_pkg::LD_WAIT && nv_valid) begin
            words_reg[nv_addr] <= nv_rdata;
        end
    end

    assign nv_req        = (state_reg == cwd_pkg::LD_REQ);
    assign nv.done       = (state_reg == cwd_pkg::LD_DONE);
    assign nv.word_one   = words_reg[0];
    assign nv.word_two   = words_reg[1];
    assign nv.word_three = words_reg[2];
    assign nv.word_four  = words_reg[3];
endmodule

// >>> logic/cwd_decoder.sv
/*
 configuration word decoder: loads words after reset, decodes clock,
 watchdog, protection, pin placement and pin-select lock settings,
 and exposes them over an ahb-lite slave.
 assumes: one nonvolatile word port, single-word ahb-lite transfers.
*/
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cwd_decoder (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             nv_req,
    output logic [1:0]       nv_addr,
    input  wire logic [23:0] nv_rdata,
    input  wire logic        nv_valid,
    input  wire logic        software_watchdog_enable,
    input  wire logic        cpu_sleeping,
    input  wire logic        low_level_prog_mode,
    output logic             config_valid,
    output logic [2:0]       initial_osc_select,
    output logic             watchdog_enable,
    output logic [7:0]       watchdog_prescale,
    output logic             code_protect_all,
    output logic             prog_write_block,
    output logic             i2c_use_default_pins,
    output logic [1:0]       emulator_pin_pair,
    output logic             emulator_placement_bad,
    output logic             two_speed_startup_enable,
    output logic             config_page_protected,
    output logic             debug_port_enable,
    output logic             pin_select_lock,
    output logic             pin_select_write_ok
);
    cwd_nv_if nv ();

    logic        start_reg;
    logic [23:0] w1;
    logic [23:0] w2;
    logic [23:0] w3;
    logic [23:0] w4;
    logic        ap_valid_reg;
    logic        ap_write_reg;
    logic [7:0]  ap_addr_reg;
    logic        unlock_stage_reg;
    logic        unlocked_reg;
    logic        lock_set_once_reg;
    logic        debug_override_reg;
    logic        debug_value_reg;
    logic        refused_reg;
    logic        wr_pin_lock;
    logic        wr_prog_ctrl;
    logic        lock_req;
    logic [1:0]  wdt_mode;
    logic        one_way;

    // ----------------------------------------------------------------
    // word loading after reset
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_reg <= 1'b1;
        end else begin
            start_reg <= 1'b0;
        end
    end

    assign nv.start = start_reg;

    cwd_word_loader u_loader (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .nv       (nv.loader),
        .nv_req   (nv_req),
        .nv_addr  (nv_addr),
        .nv_rdata (nv_rdata),
        .nv_valid (nv_valid)
    );

    // words held until the next reset; upper byte ignored
    assign w1 = nv.word_one;
    assign w2 = nv.word_two;
    assign w3 = nv.word_three;
    assign w4 = nv.word_four;
    assign config_valid = nv.done;

    // ----------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------
    assign initial_osc_select = w2[cwd_pkg::W2_OSC_LO +: 3];
    assign wdt_mode = w1[cwd_pkg::W1_WDT_MODE_LO +: 2];

    always_comb begin
        unique case (wdt_mode)
            cwd_pkg::WDT_HW_ON:  watchdog_enable = 1'b1;
            cwd_pkg::WDT_SOFT:   watchdog_enable = software_watchdog_enable;
            cwd_pkg::WDT_ACTIVE: watchdog_enable = !cpu_sleeping;
            cwd_pkg::WDT_OFF:    watchdog_enable = 1'b0;
        endcase
    end

    assign watchdog_prescale = w1[cwd_pkg::W1_WDT_PRESC] ? cwd_pkg::PRESC_128 : cwd_pkg::PRESC_32;
    assign code_protect_all  = !w1[cwd_pkg::W1_CODE_PROT];
    assign prog_write_block  = !w1[cwd_pkg::W1_WRITE_PROT];
    assign i2c_use_default_pins = w4[cwd_pkg::W4_I2C_LOC];

    // pair index 1..3 from codes 11..01; reserved code flagged
    assign emulator_pin_pair      = 2'h3 - w1[cwd_pkg::W1_EMU_LO +: 2] + 2'h1;
    assign emulator_placement_bad = (w1[cwd_pkg::W1_EMU_LO +: 2] == cwd_pkg::EMU_RSVD);
    assign two_speed_startup_enable = w2[cwd_pkg::W2_TWO_SPEED];

    assign config_page_protected = w3[cwd_pkg::W3_END_SEL]
        || (w3[cwd_pkg::W3_PAGE_LO +: 7] == cwd_pkg::CFG_PAGE_ID)
        || !w3[cwd_pkg::W3_CFG_PAGE];

    // ----------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= 8'h00;
        end else if (hready) begin
            ap_valid_reg <= hsel && htrans[1];
            ap_write_reg <= hwrite;
            ap_addr_reg  <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign wr_pin_lock  = ap_valid_reg && ap_write_reg && ap_addr_reg == cwd_pkg::OFF_PIN_LOCK;
    assign wr_prog_ctrl = ap_valid_reg && ap_write_reg && ap_addr_reg == cwd_pkg::OFF_PROG_CTRL;
    assign lock_req     = hwdata[cwd_pkg::PL_LOCK];
    assign one_way      = w4[cwd_pkg::W4_ONE_WAY];

    // ----------------------------------------------------------------
    // pin-select lock with two-write unlock key
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlock_stage_reg  <= 1'b0;
            unlocked_reg      <= 1'b0;
            pin_select_lock   <= 1'b0;
            lock_set_once_reg <= 1'b0;
            refused_reg       <= 1'b0;
        end else if (wr_pin_lock) begin
            unlock_stage_reg <= (hwdata[31:16] == cwd_pkg::UNLOCK_KEY_A);
            unlocked_reg     <= unlock_stage_reg && (hwdata[31:16] == cwd_pkg::UNLOCK_KEY_B);
            if (hwdata[31:16] == 16'h0000) begin
                if (!unlocked_reg) begin
                    refused_reg <= 1'b1;
                end else if (one_way) begin
                    if (lock_req && !lock_set_once_reg) begin
                        pin_select_lock   <= 1'b1;
                        lock_set_once_reg <= 1'b1;
                    end else if (lock_req != pin_select_lock) begin
                        refused_reg <= 1'b1;
                    end
                end else begin
                    pin_select_lock <= lock_req;
                end
                unlocked_reg <= 1'b0;
            end
        end
    end

    assign pin_select_write_ok = !pin_select_lock;

    // ----------------------------------------------------------------
    // debug port enable, changeable only in low-level mode
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            debug_override_reg <= 1'b0;
            debug_value_reg    <= 1'b0;
        end else if (wr_prog_ctrl && low_level_prog_mode) begin
            debug_override_reg <= 1'b1;
            debug_value_reg    <= hwdata[0];
        end
    end

    assign debug_port_enable = debug_override_reg ? debug_value_reg : w1[cwd_pkg::W1_DEBUG_EN];

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        hrdata = 32'h0000_0000;
        if (ap_valid_reg && !ap_write_reg) begin
            unique case (ap_addr_reg)
                cwd_pkg::OFF_CFG_ONE:   hrdata = {8'h00, w1};
                cwd_pkg::OFF_CFG_TWO:   hrdata = {8'h00, w2};
                cwd_pkg::OFF_CFG_FOUR:  hrdata = {8'h00, w4};
                cwd_pkg::OFF_STATUS:    hrdata = {29'h0, refused_reg, emulator_placement_bad, config_valid};
                cwd_pkg::OFF_PIN_LOCK:  hrdata = {30'h0, unlocked_reg, pin_select_lock};
                cwd_pkg::OFF_PROG_CTRL: hrdata = {31'h0, debug_port_enable};
                cwd_pkg::OFF_DECODED:   hrdata = {16'h0, watchdog_prescale, 1'b0, initial_osc_select,
                                                  watchdog_enable, config_page_protected,
                                                  prog_write_block, code_protect_all};
                default:                hrdata = 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> verification/cwd_nv_model.sv
/*
 behavioural nonvolatile word store answering the decoder's word loader.
 assumes: one request at a time, words given by the bench, hclk domain.
*/
`timescale 1ns/1ps
module cwd_nv_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        nv_req,
    input  wire logic [1:0]  nv_addr,
    input  wire logic        slow,
    input  wire logic [23:0] word_one,
    input  wire logic [23:0] word_two,
    input  wire logic [23:0] word_three,
    input  wire logic [23:0] word_four,
    output logic [23:0]      nv_rdata,
    output logic             nv_valid
);
    logic        busy;
    logic [3:0]  wait_cnt;
    logic [1:0]  addr_q;
    logic [23:0] last_q;
    logic [23:0] pick;

    // upper byte always programmed as zero
    assign pick = {8'h00, addr_q == 2'h0 ? word_one[15:0] : addr_q == 2'h1 ? word_two[15:0] :
                   addr_q == 2'h2 ? word_three[15:0] : word_four[15:0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy     <= 1'b0;
            wait_cnt <= 4'h0;
            addr_q   <= 2'h0;
            last_q   <= 24'h000000;
            nv_valid <= 1'b0;
            nv_rdata <= 24'hffffff;
        end else begin
            nv_valid <= 1'b0;
            nv_rdata <= ~last_q;
            if (!busy && nv_req) begin
                busy     <= 1'b1;
                addr_q   <= nv_addr;
                wait_cnt <= slow ? 4'h5 : 4'h1;
            end else if (busy && wait_cnt == 4'h1) begin
                busy     <= 1'b0;
                nv_valid <= 1'b1;
                nv_rdata <= pick;
                last_q   <= pick;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule

// >>> verification/cwd_decoder_chk.sv
/*
 port checker for the configuration word decoder.
 assumes: bound into cwd_decoder; one word arrives per nv_valid pulse.
*/
`timescale 1ns/1ps
module cwd_decoder_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [1:0]  nv_addr,
    input wire logic [23:0] nv_rdata,
    input wire logic        nv_valid,
    input wire logic        software_watchdog_enable,
    input wire logic        cpu_sleeping,
    input wire logic        config_valid,
    input wire logic [2:0]  initial_osc_select,
    input wire logic        watchdog_enable,
    input wire logic [7:0]  watchdog_prescale,
    input wire logic        code_protect_all,
    input wire logic        prog_write_block,
    input wire logic [1:0]  emulator_pin_pair,
    input wire logic        config_page_protected,
    input wire logic        pin_select_lock
);
    logic [23:0] w [4];

    // shadow of the loaded words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w <= '{default: 24'hffffff};
        end else if (nv_valid) begin
            w[nv_addr] <= nv_rdata;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_osc_field: assert property (config_valid |-> initial_osc_select == w[1][10:8])
        else $error("oscillator select differs from word two");
    a_wdt_hw_on: assert property (config_valid && w[0][7:6] == 2'h3 |-> watchdog_enable)
        else $error("watchdog off in hardware-on mode");
    a_wdt_soft: assert property (config_valid && w[0][7:6] == 2'h2 |-> watchdog_enable == software_watchdog_enable)
        else $error("watchdog does not follow software enable");
    a_wdt_awake: assert property (config_valid && w[0][7:6] == 2'h1 |-> watchdog_enable == !cpu_sleeping)
        else $error("watchdog wrong in awake-only mode");
    a_wdt_off: assert property (config_valid && w[0][7:6] == 2'h0 |-> !watchdog_enable)
        else $error("watchdog on in disabled mode");
    a_presc_ratio: assert property (config_valid |-> watchdog_prescale == (w[0][4] ? 8'h80 : 8'h20))
        else $error("watchdog prescale wrong");
    a_mem_protect: assert property (config_valid |-> code_protect_all != w[0][13] && prog_write_block != w[0][12])
        else $error("program memory protection wrong");
    a_emu_pair: assert property (config_valid |-> emulator_pin_pair == 2'(~w[0][9:8] + 2'h1))
        else $error("emulator pin pair wrong");
    a_page_prot: assert property (config_valid |-> config_page_protected == (w[2][7] || w[2][6:0] == 7'h7f || !w[2][8]))
        else $error("configuration page protection wrong");
    a_lock_once: assert property (config_valid && w[3][15] && pin_select_lock |=> pin_select_lock)
        else $error("one-way lock released");
    a_words_held: assert property (config_valid |=> config_valid && $stable(initial_osc_select))
        else $error("decoded settings changed before reset");

    c_locked: cover property (config_valid && pin_select_lock);
    c_sleep_wdt: cover property (config_valid && cpu_sleeping && watchdog_enable);
    c_page_prot: cover property (config_valid && config_page_protected);
endmodule

bind cwd_decoder cwd_decoder_chk u_chk (.*);

// >>> verification/tb.sv
/*
 testbench for the configuration word decoder.
 assumes: ahb-lite single word transfers, one slave, partner word store.
*/
`timescale 1ns/1ps
module tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd_q, q;
    logic [1:0]  htrans, nv_addr, emulator_pin_pair;
    logic [2:0]  hsize, initial_osc_select, c;
    logic        nv_req, nv_valid, slow, software_watchdog_enable, cpu_sleeping, low_level_prog_mode;
    logic [23:0] nv_rdata, w1, w2, w3, w4;
    logic        config_valid, watchdog_enable, code_protect_all, prog_write_block, i2c_use_default_pins;
    logic        emulator_placement_bad, two_speed_startup_enable, config_page_protected;
    logic        debug_port_enable, pin_select_lock, pin_select_write_ok;
    logic [7:0]  watchdog_prescale;
    int          err_count, check_count;

    assign hready = hreadyout;

    cwd_decoder u_dut (.*);
    cwd_nv_model u_nv (.hclk(hclk), .hresetn(hresetn), .nv_req(nv_req), .nv_addr(nv_addr), .slow(slow),
        .word_one(w1), .word_two(w2), .word_three(w3), .word_four(w4), .nv_rdata(nv_rdata), .nv_valid(nv_valid));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    always @(posedge hclk) rd_q <= hrdata;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        #1 q = rd_q;
    endtask

    task automatic unlock();
        bus(1'b1, 8'h10, {cwd_pkg::UNLOCK_KEY_A, 16'h0});
        bus(1'b1, 8'h10, {cwd_pkg::UNLOCK_KEY_B, 16'h0});
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        summarize();
    end

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, slow} = '0;
        {software_watchdog_enable, cpu_sleeping, low_level_prog_mode, w1, w2, w3, w4} = '0;
        hsize = 3'b010;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            // ----------------------------------------------------------------
            // reload a fresh word set through reset
            // ----------------------------------------------------------------
            @(posedge hclk);
            hresetn <= 1'b0;
            w1 <= {8'h00, 2'b01, c[0], c[1], 2'b00, c[2:1], c[1:0], 1'b0, c[2], 4'h0};
            w2 <= {8'h00, c[0], 4'h0, c, 8'h00};
            w3 <= {8'h00, 7'h00, c != 3'd3, c == 3'd0, (c == 3'd1) ? 7'h7f : {4'h0, c}};
            w4 <= {8'h00, c[0], c[1], 14'h0};
            slow <= c[0];
            repeat (6) @(posedge hclk);
            hresetn <= 1'b1;
            for (int n = 0; n < 300 && config_valid !== 1'b1; n++) @(posedge hclk);
            #1 check(config_valid, 1);
            check(initial_osc_select, c);
            check(watchdog_prescale, c[2] ? 8'h80 : 8'h20);
            check(code_protect_all, !c[0]);
            check(prog_write_block, !c[1]);
            check(i2c_use_default_pins, c[1]);
            check(emulator_pin_pair, 2'(~c[2:1] + 2'h1));
            check(emulator_placement_bad, c[2:1] == 2'h0);
            check(two_speed_startup_enable, c[0]);
            check(config_page_protected, c <= 3'd1 || c == 3'd3);
            for (int s = 0; s < 4; s++) begin
                @(posedge hclk);
                software_watchdog_enable <= s[0];
                cpu_sleeping <= s[1];
                @(negedge hclk);
                check(watchdog_enable, c[1:0] == 2'h3 || (c[1:0] == 2'h2 && s[0]) || (c[1:0] == 2'h1 && !s[1]));
            end
            // ----------------------------------------------------------------
            // read-only words, unmapped place, debug override
            // ----------------------------------------------------------------
            bus(1'b1, 8'h00, 32'h0);
            bus(1'b0, 8'h00, 32'h0);
            check(q, {8'h0, w1});
            bus(1'b0, 8'h04, 32'h0);
            check(q, {8'h0, w2});
            bus(1'b0, 8'h08, 32'h0);
            check(q, {8'h0, w4});
            bus(1'b0, 8'h40, 32'h0);
            check(hresp, 0);
            check(q, 32'h0);
            bus(1'b1, 8'h14, 32'h0);
            check(debug_port_enable, 1);
            @(posedge hclk);
            low_level_prog_mode <= 1'b1;
            bus(1'b1, 8'h14, 32'h0);
            check(debug_port_enable, 0);
            @(posedge hclk);
            low_level_prog_mode <= 1'b0;
            bus(1'b0, 8'h18, 32'h0);
            check(q, {16'h0, c[2] ? 8'h80 : 8'h20, 1'b0, c, c[1], c <= 3'd1 || c == 3'd3, !c[1], !c[0]});
            // ----------------------------------------------------------------
            // pin-select lock
            // ----------------------------------------------------------------
            bus(1'b1, 8'h10, 32'h1);
            check(pin_select_lock, 0);
            bus(1'b0, 8'h0c, 32'h0);
            check(q, {29'h0, 1'b1, c[2:1] == 2'h0, 1'b1});
            unlock();
            bus(1'b1, 8'h10, 32'h1);
            check(pin_select_lock, 1);
            check(pin_select_write_ok, 0);
            unlock();
            bus(1'b0, 8'h10, 32'h0);
            check(q, {30'h0, 2'b11});
            bus(1'b1, 8'h10, 32'h0);
            check(pin_select_lock, c[0]);
            check(pin_select_write_ok, !c[0]);
        end
        summarize();
    end
endmodule
